// ==== src/psa_program_space_access.sv ====
// program space access: fetch, table and visibility window address paths
//
// Behaviour
// - bridge 24-bit program and 16-bit data words
// - program-space constants read with consistent alignment
// - table access reaches anywhere, byte or word
// - table path reads, writes, reaches upper byte
// - window maps program into data, read-only
// - window returns only low 16-bit word
// - fetch address: bit 23 zero, PC<22:1>
// - table address: page above effective address
`timescale 1ns/1ps
`include "psa_defines.svh"

module psa_program_space_access (
  input wire logic clk, // 125 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic reqValid, // core offers a request
  output logic reqReady, // block takes the request
  input wire psa_pkg::psa_req_s req, // request contents
  output psa_pkg::psa_pm_s pm, // program memory request
  input wire logic pmAck, // program memory done
  input wire logic [23:0] pmRdata, // program memory read word
  output psa_pkg::psa_rsp_s rsp // answer to the core
);
  import psa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rstSync1_ff; // first stage, read only by the second
  logic rstSync2_ff; // synchronised reset, active low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and its next value
  psa_st_s st_ff; // registered state
  psa_st_s nxt_st; // next state
  logic [23:0] addrCalc; // program address of the incoming request
  logic [2:0] enCalc; // write lanes of the incoming request
  logic [23:0] wdCalc; // placed write data
  logic [23:0] rdSel; // read data picked from memory word
  logic take; // request accepted this cycle

  assign reqReady = (st_ff.state == PSA_IDLE);
  assign take = reqValid && reqReady;
  assign pm = st_ff.pm;
  assign rsp = st_ff.rsp;

  ////////////////////////////////////////////////////////////////////////
  // address construction for each path
  always_comb begin
    addrCalc = '0;
    case (req.kind)
      PSA_FETCH: begin
        // fetches never leave user space
        addrCalc = {1'b0, req.pc[`PSA_PC_HI:`PSA_PC_LO], 1'b0};
      end
      PSA_TBL_RD, PSA_TBL_WR: begin
        // page on top, word address below; lsb only picks the byte
        addrCalc = {req.tablePageSelect,
                    req.ea[`PSA_EA_HI:`PSA_EA_LO], 1'b0};
      end
      default: begin
        // window keeps ea<14:1>, the page supplies bits 23:16, bit 15 is zero
        addrCalc = {req.windowPage, 1'b0,
                    req.ea[`PSA_WIN_HI:`PSA_EA_LO], 1'b0};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // write lane selection and data placement for table writes
  always_comb begin
    enCalc = `PSA_EN_NONE;
    wdCalc = '0;
    if (req.high) begin
      // upper lane has one byte; odd byte address is a phantom
      if (!req.isByte || !req.ea[`PSA_BYTE_BIT]) begin
        enCalc = `PSA_EN_HIGH;
      end
      wdCalc = {req.wdata[7:0], 16'h0};
    end else if (!req.isByte) begin
      enCalc = `PSA_EN_LOW;
      wdCalc = {8'h0, req.wdata};
    end else if (req.ea[`PSA_BYTE_BIT]) begin
      enCalc = `PSA_EN_B1;
      wdCalc = {8'h0, req.wdata[7:0], 8'h0};
    end else begin
      enCalc = `PSA_EN_B0;
      wdCalc = {16'h0, req.wdata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data alignment for the held request
  always_comb begin
    rdSel = '0;
    case (st_ff.req.kind)
      PSA_FETCH: begin
        rdSel = pmRdata; // whole instruction word
      end
      PSA_TBL_RD: begin
        if (st_ff.req.high) begin
          // odd upper byte reads as zero
          if (!st_ff.req.isByte || !st_ff.req.ea[`PSA_BYTE_BIT]) begin
            rdSel = {16'h0, pmRdata[23:16]};
          end
        end else if (!st_ff.req.isByte) begin
          rdSel = {8'h0, pmRdata[15:0]};
        end else if (st_ff.req.ea[`PSA_BYTE_BIT]) begin
          rdSel = {16'h0, pmRdata[15:8]};
        end else begin
          rdSel = {16'h0, pmRdata[7:0]};
        end
      end
      default: begin
        // window: upper byte is never visible
        if (!st_ff.req.isByte) begin
          rdSel = {8'h0, pmRdata[15:0]};
        end else if (st_ff.req.ea[`PSA_BYTE_BIT]) begin
          rdSel = {16'h0, pmRdata[15:8]};
        end else begin
          rdSel = {16'h0, pmRdata[7:0]};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // strobes and answers are one-cycle pulses
    nxt_st.pm.rd = 1'b0;
    nxt_st.pm.wr = 1'b0;
    nxt_st.rsp.valid = 1'b0;
    nxt_st.rsp.err = 1'b0;
    case (st_ff.state)
      PSA_IDLE: begin
        if (take) begin
          if (req.kind == PSA_WIN_WR) begin
            // window is read-only: answer with a refusal, no memory cycle
            nxt_st.rsp.err = 1'b1;
          end else begin
            nxt_st.req = req;
            nxt_st.pm.addr = addrCalc;
            // fetches stay in user space whatever the page holds
            nxt_st.pm.cfgSpace = (req.kind == PSA_TBL_RD ||
                                req.kind == PSA_TBL_WR) &&
                               addrCalc[`PSA_CFG_BIT];
            nxt_st.pm.rd = (req.kind != PSA_TBL_WR);
            nxt_st.pm.wr = (req.kind == PSA_TBL_WR);
            nxt_st.pm.byteEn = (req.kind == PSA_TBL_WR) ? enCalc
                                                        : `PSA_EN_NONE;
            nxt_st.pm.wdata = (req.kind == PSA_TBL_WR) ? wdCalc : '0;
            nxt_st.state = PSA_WAIT;
          end
        end
      end
      PSA_WAIT: begin
        // memory may acknowledge with the strobe or any later cycle
        if (pmAck) begin
          nxt_st.rsp.valid = 1'b1;
          nxt_st.rsp.data = (st_ff.req.kind == PSA_TBL_WR) ? '0 : rdSel;
          nxt_st.state = PSA_IDLE;
        end
      end
      default: begin
        nxt_st.state = PSA_IDLE; // recover from an illegal code
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rstSync2_ff) begin
    if (!rstSync2_ff) begin
      st_ff <= '{state: PSA_IDLE, req: '0, pm: '0, rsp: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync2_ff);

  sequence sTake;
    take && req.kind != PSA_WIN_WR;
  endsequence

  sequence sAck;
    st_ff.state == PSA_WAIT && pmAck;
  endsequence

  a_fetch_user_space: assert property (
    pm.rd && st_ff.req.kind == PSA_FETCH |->
    pm.addr == {1'b0, st_ff.req.pc[`PSA_PC_HI:`PSA_PC_LO], 1'b0}
  ) else $error("fetch address malformed");

  a_table_addr_build: assert property (
    sTake ##0 (req.kind == PSA_TBL_RD) |=>
    pm.addr == {$past(req.tablePageSelect),
                $past(req.ea[`PSA_EA_HI:`PSA_EA_LO]), 1'b0}
  ) else $error("table address malformed");

  a_config_space_sel: assert property (
    (pm.rd || pm.wr) |->
    pm.cfgSpace == ((st_ff.req.kind == PSA_TBL_RD ||
                   st_ff.req.kind == PSA_TBL_WR) &&
                  st_ff.req.tablePageSelect[7])
  ) else $error("config space select wrong");

  a_window_read_only: assert property (
    take && req.kind == PSA_WIN_WR |=> rsp.err && !pm.wr && !pm.rd
  ) else $error("window write not refused");

  a_window_low_word: assert property (
    sAck ##0 (st_ff.req.kind == PSA_WIN_RD) |=>
    rsp.valid && rsp.data[23:16] == 8'h0
  ) else $error("window returned upper byte");

  a_byte_lane_pick: assert property (
    pm.wr && st_ff.req.isByte && !st_ff.req.high |->
    pm.byteEn == (st_ff.req.ea[`PSA_BYTE_BIT] ? `PSA_EN_B1 : `PSA_EN_B0)
  ) else $error("byte lane wrong");

  a_upper_byte_read: assert property (
    sAck ##0 (st_ff.req.kind == PSA_TBL_RD && st_ff.req.high &&
              (!st_ff.req.isByte || !st_ff.req.ea[`PSA_BYTE_BIT])) |=>
    rsp.data == {16'h0, $past(pmRdata[23:16])}
  ) else $error("upper byte read wrong");

  a_strobe_then_answer: assert property (
    // bound follows the memory's worst latency of 15 cycles after the strobe
    sTake |=> (pm.rd || pm.wr) ##0
    (!reqReady throughout (##[0:15] sAck)) ##1 (rsp.valid && reqReady)
  ) else $error("access did not complete in order");

endmodule

// ==== src/psa_defines.svh ====
// constants for the program space access address generator
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH

`define PSA_PW_W 24
`define PSA_DW_W 16
`define PSA_PAGE_W 8
`define PSA_CFG_BIT 23
`define PSA_PC_HI 22
`define PSA_PC_LO 1
`define PSA_EA_HI 15
`define PSA_EA_LO 1
`define PSA_BYTE_BIT 0
`define PSA_WIN_BIT 15
`define PSA_WIN_HI 14
`define PSA_EN_NONE 3'h0
`define PSA_EN_B0 3'h1
`define PSA_EN_B1 3'h2
`define PSA_EN_LOW 3'h3
`define PSA_EN_HIGH 3'h4

`endif

// ==== src/psa_pkg.sv ====
// types shared by the program space access address generator
package psa_pkg;

  // kind of access requested by the core
  typedef enum logic [2:0] {
    PSA_FETCH = 3'h0, // instruction fetch from program counter
    PSA_TBL_RD = 3'h1, // table_read_instr
    PSA_TBL_WR = 3'h2, // table_write_instr
    PSA_WIN_RD = 3'h3, // read through program_space_window
    PSA_WIN_WR = 3'h4 // write aimed at the window, refused
  } psa_kind_e;

  // access state, one-hot
  typedef enum logic [1:0] {
    PSA_IDLE = 2'h1,
    PSA_WAIT = 2'h2
  } psa_state_e;

  // request from the core and its address generator
  typedef struct packed {
    psa_kind_e kind; // access kind
    logic high; // table access to the upper byte lane
    logic isByte; // byte rather than word transfer
    logic [23:0] pc; // program counter
    logic [15:0] ea; // data effective address
    logic [7:0] tablePageSelect; // table page, bit 7 picks config space
    logic [7:0] windowPage; // page of the visibility window
    logic [15:0] wdata; // write data for table writes
  } psa_req_s;

  // request towards program memory
  typedef struct packed {
    logic rd; // read strobe, one cycle
    logic wr; // write strobe, one cycle
    logic cfgSpace; // configuration space selected
    logic [23:0] addr; // program space byte address, bit 0 zero
    logic [2:0] byteEn; // byte lanes written
    logic [23:0] wdata; // write word, lanes placed
  } psa_pm_s;

  // answer to the core
  typedef struct packed {
    logic valid; // one-cycle answer pulse
    logic err; // one-cycle refusal pulse
    logic [23:0] data; // read data, right aligned
  } psa_rsp_s;

  // whole state of the block
  typedef struct packed {
    psa_state_e state;
    psa_req_s req;
    psa_pm_s pm;
    psa_rsp_s rsp;
  } psa_st_s;

endpackage

// ==== testbench/psa_mem_model.sv ====
// program memory model that answers the access block
`timescale 1ns/1ps

module psa_mem_model (
  input wire logic clk, // system clock
  input wire logic rst_b, // reset, active low
  input wire psa_pkg::psa_pm_s pm, // request from the block
  input wire logic [3:0] ackDelay, // cycles from strobe to acknowledge
  output logic pmAck, // access done
  output logic [23:0] pmRdata // read word, inverted while not acked
);
  import psa_pkg::*;
  logic [23:0] mem [256]; // 24-bit program words
  logic [7:0] idx; // space bit plus low word address
  logic busy; // access outstanding
  logic [3:0] cnt; // cycles left before acknowledge
  assign idx = {pm.addr[23], pm.addr[7:1]};
  ////////////////////////////////////////////////////////////////////
  // fixed pattern, so the bench can predict every unwritten word
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0], ~i[7:0], i[7:0] ^ 8'h3c};
    end
  end
  // slow answers: count down from the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if ((pm.rd || pm.wr) && !pmAck) begin
      busy <= 1'b1;
      cnt <= ackDelay - 4'h1;
    end else if (pmAck) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign pmAck = (pm.rd || pm.wr) ? (ackDelay == 4'h0) : (busy && cnt == 4'h0);
  // data shown only on the ack cycle, never a stale copy
  assign pmRdata = pmAck ? mem[idx] : ~mem[idx];
  // lane writes on the strobe edge
  always @(posedge clk) begin
    for (int b = 0; b < 3; b++) begin
      if (pm.wr && pm.byteEn[b]) begin
        mem[idx][8*b +: 8] <= pm.wdata[8*b +: 8];
      end
    end
  end
endmodule

// ==== testbench/test_program_space_access_addr.sv ====
// self-checking bench for the program space access block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module test_program_space_access_addr;
  import psa_pkg::*;
  logic clk = 1'b0; // system clock
  logic rst_b = 1'b0; // reset, active low
  logic reqValid = 1'b0; // request offered
  logic reqReady; // block idle
  psa_req_s req = '0; // request contents
  psa_pm_s pm; // memory request
  logic pmAck; // memory done
  logic [23:0] pmRdata; // memory word
  psa_rsp_s rsp; // answer
  logic [3:0] ackDelay = 4'h0; // memory latency
  psa_pm_s pmSeen; // strobed memory request
  psa_rsp_s rspSeen; // answer pulse seen
  logic [23:0] w; // expected word
  int mismatches = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  psa_program_space_access psa_program_space_access_inst (.clk(clk),
    .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .pm(pm), .pmAck(pmAck), .pmRdata(pmRdata), .rsp(rsp));
  psa_mem_model psa_mem_model_inst (.clk(clk), .rst_b(rst_b), .pm(pm),
    .ackDelay(ackDelay), .pmAck(pmAck), .pmRdata(pmRdata));
  ////////////////////////////////////////////////////////////////////
  // unwritten word at a byte address, same pattern as the model
  function automatic logic [23:0] word0(input logic [23:0] a);
    logic [7:0] i;
    i = {a[23], a[7:1]};
    return {i, ~i, i ^ 8'h3c};
  endfunction
  // one whole access; request held until the edge that takes it
  task automatic access(input psa_kind_e k, input logic hi, input logic byt,
    input logic [23:0] pc, input logic [15:0] ea, input logic [7:0] pg,
    input logic [15:0] wd);
    pmSeen = '0;
    rspSeen = '0;
    req = '{k, hi, byt, pc, ea, pg, pg, wd};
    reqValid = 1'b1;
    for (int n = 0; n < 50 && reqReady !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    for (int n = 0; n < 50; n++) begin
      if (pm.rd || pm.wr) pmSeen = pm;
      if (rsp.valid || rsp.err) begin
        rspSeen = rsp;
        break;
      end
      @(posedge clk);
      #1;
    end
    `CHK("answer", 1'b1, rspSeen.valid | rspSeen.err)
  endtask
  // fetch ignores pc bit 23 and bit 0, full word back
  task testFetch;
    access(PSA_FETCH, 1'b0, 1'b0, 24'hfedcbb, 16'h0, 8'h80, 16'h0);
    `CHK("fetch rd", 1'b1, pmSeen.rd)
    `CHK("fetch addr", 24'h7edcba, pmSeen.addr)
    `CHK("fetch cfg", 1'b0, pmSeen.cfgSpace)
    `CHK("fetch data", word0(24'h7edcba), rspSeen.data)
  endtask
  // table reads in both spaces, byte lanes, slow memory
  task testTableRead;
    ackDelay = 4'h3;
    access(PSA_TBL_RD, 1'b0, 1'b0, 24'h0, 16'h1235, 8'h80, 16'h0);
    w = word0(24'h801234);
    `CHK("tbl addr", 24'h801234, pmSeen.addr)
    `CHK("tbl cfg", 1'b1, pmSeen.cfgSpace)
    `CHK("tbl word", w[15:0], rspSeen.data[15:0])
    access(PSA_TBL_RD, 1'b0, 1'b0, 24'h0, 16'h1234, 8'h12, 16'h0);
    `CHK("usr cfg", 1'b0, pmSeen.cfgSpace)
    `CHK("usr addr", 24'h121234, pmSeen.addr)
    access(PSA_TBL_RD, 1'b0, 1'b1, 24'h0, 16'h0047, 8'h05, 16'h0);
    w = word0(24'h050046);
    `CHK("odd byte", w[15:8], rspSeen.data[7:0])
    access(PSA_TBL_RD, 1'b1, 1'b1, 24'h0, 16'h0046, 8'h05, 16'h0);
    `CHK("high byte", w[23:16], rspSeen.data[7:0])
    // odd byte of the upper lane is a phantom and reads as zero
    access(PSA_TBL_RD, 1'b1, 1'b1, 24'h0, 16'h0047, 8'h05, 16'h0);
    `CHK("odd high", 24'h0, rspSeen.data)
  endtask
  // word, upper and odd byte writes, read back by fetch
  task testTableWrite;
    ackDelay = 4'h1;
    access(PSA_TBL_WR, 1'b0, 1'b0, 24'h0, 16'h0040, 8'h01, 16'hbeef);
    `CHK("wr strobe", 1'b1, pmSeen.wr)
    `CHK("wr addr", 24'h010040, pmSeen.addr)
    `CHK("wr lanes", 3'h3, pmSeen.byteEn)
    `CHK("wr word", 16'hbeef, pmSeen.wdata[15:0])
    `CHK("wr rsp", 24'h0, rspSeen.data)
    access(PSA_TBL_WR, 1'b1, 1'b1, 24'h0, 16'h0040, 8'h01, 16'h0077);
    `CHK("hi lanes", 3'h4, pmSeen.byteEn)
    `CHK("hi data", 8'h77, pmSeen.wdata[23:16])
    access(PSA_TBL_WR, 1'b0, 1'b1, 24'h0, 16'h0041, 8'h01, 16'h0011);
    `CHK("odd lanes", 3'h2, pmSeen.byteEn)
    `CHK("odd data", 8'h11, pmSeen.wdata[15:8])
    // phantom upper byte: strobed but no lane, readback stays intact
    access(PSA_TBL_WR, 1'b1, 1'b1, 24'h0, 16'h0041, 8'h01, 16'h0099);
    `CHK("odd hi wr", 1'b1, pmSeen.wr)
    `CHK("odd hi lanes", 3'h0, pmSeen.byteEn)
    access(PSA_FETCH, 1'b0, 1'b0, 24'h010040, 16'h0, 8'h0, 16'h0);
    `CHK("readback", 24'h7711ef, rspSeen.data)
  endtask
  // window reads low word only; one write refused between two reads
  task testWindow;
    ackDelay = 4'h2;
    access(PSA_WIN_RD, 1'b0, 1'b0, 24'h0, 16'h8046, 8'h03, 16'h0);
    w = word0(24'h030046);
    `CHK("win addr", 24'h030046, pmSeen.addr)
    `CHK("win cfg", 1'b0, pmSeen.cfgSpace)
    `CHK("win data", w[15:0], rspSeen.data[15:0])
    access(PSA_WIN_WR, 1'b0, 1'b0, 24'h0, 16'h8046, 8'h03, 16'h1234);
    `CHK("win err", 1'b1, rspSeen.err)
    `CHK("win no wr", 1'b0, pmSeen.wr | pmSeen.rd)
    access(PSA_WIN_RD, 1'b0, 1'b0, 24'h0, 16'h8046, 8'h03, 16'h0);
    `CHK("win again", w[15:0], rspSeen.data[15:0])
  endtask
  task complete_run;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("idle ready", 1'b1, reqReady)
    testFetch();
    testTableRead();
    testTableWrite();
    testWindow();
    complete_run();
  end
  // hang guard, far beyond the sixty or so cycles needed
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
endmodule
